//--- hdl/ssv_pkg.sv
package ssv_pkg;
	typedef enum logic [3:0] {
		SSV_ALU_NONE,
		SSV_ALU_ADD,
		SSV_ALU_ADC,
		SSV_ALU_SUB,
		SSV_ALU_SBC,
		SSV_ALU_AND,
		SSV_ALU_OR,
		SSV_ALU_XOR
	} ssv_alu_op_e;

	typedef enum logic [2:0] {
		SSV_STK_NONE,
		SSV_STK_PUSH,
		SSV_STK_POP,
		SSV_STK_CALL,
		SSV_STK_SUB_RETURN,
		SSV_STK_INT_RETURN
	} ssv_stack_op_e;
endpackage : ssv_pkg

//--- hdl/ssv_regs.svh
`ifndef SSV_REGS_SVH
`define SSV_REGS_SVH

// I/O space locations
`define SSV_ADDR_STATUS 6'h3F
`define SSV_ADDR_PTR_HIGH 6'h3E
`define SSV_ADDR_PTR_LOW 6'h3D

// Status bit positions
`define SSV_BIT_I 7
`define SSV_BIT_T 6
`define SSV_BIT_H 5
`define SSV_BIT_S 4
`define SSV_BIT_V 3
`define SSV_BIT_N 2
`define SSV_BIT_Z 1
`define SSV_BIT_C 0

// Reset values
`define SSV_STATUS_RST 8'h00
`define SSV_PTR_RST 10'h000
`define SSV_BYTE_ZERO 8'h00

// Stack pointer geometry and steps
`define SSV_PTR_W 10
`define SSV_PTR_HIGH_W 2
`define SSV_PTR_ONE 10'h001
`define SSV_PTR_TWO 10'h002

// Vector table
`define SSV_NUM_IRQ 16
`define SSV_VEC_W 5
`define SSV_VEC_RESET 5'h00
`define SSV_VEC_FIRST_IRQ 5'h01

// Source index; vector is index plus first vector
`define SSV_IRQ_EXT0 0
`define SSV_IRQ_EXT1 1
`define SSV_IRQ_T2_COMP 2
`define SSV_IRQ_T2_OVF 3
`define SSV_IRQ_T1_CAPT 4
`define SSV_IRQ_T1_COMPA 5
`define SSV_IRQ_T1_COMPB 6
`define SSV_IRQ_T1_OVF 7
`define SSV_IRQ_T0_OVF 8
`define SSV_IRQ_SPI_DONE 9
`define SSV_IRQ_SER_RX 10
`define SSV_IRQ_SER_TX_EMPTY 11
`define SSV_IRQ_SER_TX 12
`define SSV_IRQ_CONV_DONE 13
`define SSV_IRQ_NVM_READY 14
`define SSV_IRQ_ANALOG_CMP 15

`endif

//--- hdl/ssv_status_stack_vector_unit.sv
`timescale 1ns/1ps
`include "ssv_regs.svh"

// Operation
// - Half-carry in status bit 5 on carry out of low nibble.
// - Sign bit 4 always equals negative XOR overflow.
// - Overflow bit 3 set by signed overflow of arithmetic.
// - Negative bit 2 set on negative arithmetic or logic result.
// - Zero bit 1 set on zero arithmetic or logic result.
// - Carry bit 0 reflects carry of the operation.
// - Status is not saved or restored on interrupt entry or return.
// - Stack pointer is low and high byte, 10 bits, upper bits read zero.
// - Data push decrements pointer by one, pop increments by one.
// - Call or interrupt decrements by two, returns increment by two.
// - Sixteen interrupt sources plus reset, each with own vector.
// - Interrupt taken only with source enable and global enable set.
// - Vectors at lowest addresses; lower address wins priority.
// - Reset vectors to zero and has highest priority.
// - External 0, 1, timer 2 compare and overflow vector 0x01 to 0x04.
// - Timer 1 capture, compares, overflow and timer 0 vector 0x05 to 0x09.
// - SPI and serial events vector 0x0A to 0x0D.
// - Converter, memory ready and comparator vector 0x0E to 0x10.
// - Global enable bit 7 cleared on entry, set by interrupt return.
// - Serviced source's pending flag cleared when vectoring.
module ssv_status_stack_vector_unit (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// I/O space register port
	input wire logic [5:0] ioAddr,
	input wire logic ioWrEn,
	input wire logic [7:0] ioWrData,
	input wire logic ioRdEn,
	output logic [7:0] ioRdData,
	// Arithmetic operation from datapath
	input wire ssv_pkg::ssv_alu_op_e aluOp,
	input wire logic [7:0] aluOperandA,
	input wire logic [7:0] aluOperandB,
	output logic [7:0] aluResult,
	// Stack operation and instruction boundary
	input wire ssv_pkg::ssv_stack_op_e stackOp,
	input wire logic instrDone,
	output logic [9:0] stackPointer,
	output logic [7:0] statusFlags,
	// Interrupt requests and vectoring
	input wire logic [15:0] irqPending,
	input wire logic [15:0] irqEnable,
	output logic [15:0] irqAck,
	output logic vectorValid,
	output logic [4:0] vectorAddr
);
	import ssv_pkg::*;

	logic flagI, flagT, flagH, flagV, flagN, flagZ, flagC;
	logic flagS;
	logic resetVecDone;
	logic [7:0] aluRes;
	logic aluH, aluV, aluC, aluArith;
	logic [4:0] nib;
	logic [8:0] wide;
	logic cin;
	logic [15:0] irqLive;
	logic anyLive;
	logic [3:0] winIdx;
	logic takeIrq;
	logic wrStatus, wrPtrLow, wrPtrHigh;
	logic [9:0] next_stackPointer;
	// Macro literals cannot be bit-selected, so name the value
	localparam logic [7:0] statusRst = `SSV_STATUS_RST;

	assign wrStatus = ioWrEn && (ioAddr == `SSV_ADDR_STATUS);
	assign wrPtrLow = ioWrEn && (ioAddr == `SSV_ADDR_PTR_LOW);
	assign wrPtrHigh = ioWrEn && (ioAddr == `SSV_ADDR_PTR_HIGH);

	// Sign derived
	// Never stored, so it cannot drift from N and V
	assign flagS = flagN ^ flagV;

	assign statusFlags = {flagI, flagT, flagH, flagS, flagV, flagN, flagZ, flagC};

	// Flag computation
	always_comb begin
		cin = 1'b0;
		nib = 5'h00;
		wide = 9'h000;
		aluRes = `SSV_BYTE_ZERO;
		aluH = flagH;
		aluV = 1'b0;
		aluC = flagC;
		aluArith = 1'b0;
		unique case (aluOp)
			SSV_ALU_NONE: begin
				aluRes = `SSV_BYTE_ZERO;
			end
			SSV_ALU_ADD, SSV_ALU_ADC: begin
				cin = (aluOp == SSV_ALU_ADC) ? flagC : 1'b0;
				nib = {1'b0, aluOperandA[3:0]} + {1'b0, aluOperandB[3:0]} + {4'h0, cin};
				wide = {1'b0, aluOperandA} + {1'b0, aluOperandB} + {8'h00, cin};
				aluRes = wide[7:0];
				aluH = nib[4];
				aluC = wide[8];
				aluV = (aluOperandA[7] & aluOperandB[7] & ~aluRes[7]) |
					(~aluOperandA[7] & ~aluOperandB[7] & aluRes[7]);
				aluArith = 1'b1;
			end
			SSV_ALU_SUB, SSV_ALU_SBC: begin
				cin = (aluOp == SSV_ALU_SBC) ? flagC : 1'b0;
				nib = {1'b0, aluOperandA[3:0]} - {1'b0, aluOperandB[3:0]} - {4'h0, cin};
				wide = {1'b0, aluOperandA} - {1'b0, aluOperandB} - {8'h00, cin};
				aluRes = wide[7:0];
				aluH = nib[4];
				aluC = wide[8];
				aluV = (aluOperandA[7] & ~aluOperandB[7] & ~aluRes[7]) |
					(~aluOperandA[7] & aluOperandB[7] & aluRes[7]);
				aluArith = 1'b1;
			end
			SSV_ALU_AND: begin
				aluRes = aluOperandA & aluOperandB;
			end
			SSV_ALU_OR: begin
				aluRes = aluOperandA | aluOperandB;
			end
			SSV_ALU_XOR: begin
				aluRes = aluOperandA ^ aluOperandB;
			end
			default: begin
				aluRes = `SSV_BYTE_ZERO;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aluResult <= `SSV_BYTE_ZERO;
		end else if (aluOp != SSV_ALU_NONE) begin
			aluResult <= aluRes;
		end
	end

	// Arithmetic flags; a register write wins over a flag update
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flagT <= statusRst[`SSV_BIT_T];
			flagH <= statusRst[`SSV_BIT_H];
			flagV <= statusRst[`SSV_BIT_V];
			flagN <= statusRst[`SSV_BIT_N];
			flagZ <= statusRst[`SSV_BIT_Z];
			flagC <= statusRst[`SSV_BIT_C];
		end else if (wrStatus) begin
			flagT <= ioWrData[`SSV_BIT_T];
			flagH <= ioWrData[`SSV_BIT_H];
			flagV <= ioWrData[`SSV_BIT_V];
			flagN <= ioWrData[`SSV_BIT_N];
			flagZ <= ioWrData[`SSV_BIT_Z];
			flagC <= ioWrData[`SSV_BIT_C];
		end else if (aluOp != SSV_ALU_NONE) begin
			flagN <= aluRes[7];
			flagZ <= (aluRes == `SSV_BYTE_ZERO);
			flagV <= aluV;
			flagC <= aluC;
			if (aluArith) begin
				flagH <= aluH;
			end
		end
	end

	assign irqLive = irqPending & irqEnable;
	assign anyLive = |irqLive;

	always_comb begin
		winIdx = 4'h0;
		for (int k = `SSV_NUM_IRQ - 1; k >= 0; k--) begin
			if (irqLive[k]) begin
				winIdx = 4'(k);
			end
		end
	end

	assign takeIrq = resetVecDone && instrDone && flagI && anyLive;

	// Global interrupt enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flagI <= statusRst[`SSV_BIT_I];
		end else if (takeIrq) begin
			flagI <= 1'b0;
		end else if (wrStatus) begin
			flagI <= ioWrData[`SSV_BIT_I];
		end else if (instrDone && stackOp == SSV_STK_INT_RETURN) begin
			flagI <= 1'b1;
		end
	end

	// Stack pointer arithmetic
	always_comb begin
		next_stackPointer = stackPointer;
		unique case (stackOp)
			SSV_STK_NONE: next_stackPointer = stackPointer;
			SSV_STK_PUSH: next_stackPointer = stackPointer - `SSV_PTR_ONE;
			SSV_STK_POP: next_stackPointer = stackPointer + `SSV_PTR_ONE;
			SSV_STK_CALL: next_stackPointer = stackPointer - `SSV_PTR_TWO;
			SSV_STK_SUB_RETURN, SSV_STK_INT_RETURN: next_stackPointer = stackPointer + `SSV_PTR_TWO;
			default: next_stackPointer = stackPointer;
		endcase
		if (takeIrq) begin
			next_stackPointer = next_stackPointer - `SSV_PTR_TWO;
		end
		if (wrPtrLow) begin
			next_stackPointer[7:0] = ioWrData;
		end
		if (wrPtrHigh) begin
			next_stackPointer[`SSV_PTR_W-1:8] = ioWrData[`SSV_PTR_HIGH_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stackPointer <= `SSV_PTR_RST;
		end else begin
			stackPointer <= next_stackPointer;
		end
	end

	// Vector dispatch; reset vector is issued once after release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			resetVecDone <= 1'b0;
			vectorValid <= 1'b0;
			vectorAddr <= `SSV_VEC_RESET;
		end else if (!resetVecDone) begin
			resetVecDone <= 1'b1;
			vectorValid <= 1'b1;
			vectorAddr <= `SSV_VEC_RESET;
		end else if (takeIrq) begin
			vectorValid <= 1'b1;
			vectorAddr <= `SSV_VEC_FIRST_IRQ + {1'b0, winIdx};
		end else begin
			vectorValid <= 1'b0;
		end
	end

	generate
		for (genvar g = 0; g < `SSV_NUM_IRQ; g++) begin : g_ack
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					irqAck[g] <= 1'b0;
				end else begin
					irqAck[g] <= takeIrq && (winIdx == 4'(g));
				end
			end
		end
	endgenerate

	// Register read, unused high bits zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ioRdData <= `SSV_BYTE_ZERO;
		end else if (ioRdEn) begin
			unique case (ioAddr)
				`SSV_ADDR_STATUS: ioRdData <= statusFlags;
				`SSV_ADDR_PTR_LOW: ioRdData <= stackPointer[7:0];
				`SSV_ADDR_PTR_HIGH: ioRdData <= {6'h00, stackPointer[`SSV_PTR_W-1:8]};
				default: ioRdData <= `SSV_BYTE_ZERO;
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic plainStack;
	assign plainStack = !takeIrq && !wrPtrLow && !wrPtrHigh;

	a_sign_readback: assert property (
		ioRdEn && ioAddr == `SSV_ADDR_STATUS |=> ioRdData[`SSV_BIT_S] == ($past(flagN) ^ $past(flagV)))
		else $error("sign bit not N xor V");

	a_zero_flag: assert property (
		aluOp != SSV_ALU_NONE && !wrStatus |=> flagZ == ($past(aluRes) == `SSV_BYTE_ZERO))
		else $error("zero flag wrong");

	a_push_dec_one: assert property (
		stackOp == SSV_STK_PUSH && plainStack |=> stackPointer == $past(stackPointer) - `SSV_PTR_ONE)
		else $error("push did not step by one");

	a_call_dec_two: assert property (
		stackOp == SSV_STK_CALL && plainStack |=> stackPointer == $past(stackPointer) - `SSV_PTR_TWO)
		else $error("call did not step by two");

	a_irq_needs_gie: assert property (
		vectorValid && vectorAddr != `SSV_VEC_RESET |-> $past(flagI) && $past(anyLive) && $past(instrDone))
		else $error("interrupt without enables");

	a_entry_clears_gie: assert property (
		takeIrq |=> !flagI && vectorValid)
		else $error("global enable not cleared on entry");

	a_lowest_wins: assert property (
		takeIrq |-> ((irqLive & ((16'h0001 << winIdx) - 16'h0001)) == 16'h0000) && irqLive[winIdx])
		else $error("priority order broken");

	a_ack_matches_vec: assert property (
		|irqAck |-> $onehot(irqAck) && vectorValid && irqAck[4'(vectorAddr - `SSV_VEC_FIRST_IRQ)])
		else $error("ack and vector disagree");

	a_ptr_high_zero: assert property (
		ioRdEn && ioAddr == `SSV_ADDR_PTR_HIGH |=> ioRdData[7:`SSV_PTR_HIGH_W] == 6'h00)
		else $error("high byte upper bits not zero");

	c_irq_taken: cover property (takeIrq ##1 vectorValid);
	c_int_return: cover property (instrDone && stackOp == SSV_STK_INT_RETURN ##1 flagI);
	c_two_pending: cover property (takeIrq && $countones(irqLive) > 1);
	c_half_carry: cover property (aluOp == SSV_ALU_ADD && aluH);
endmodule : ssv_status_stack_vector_unit

//--- sim/ssv_irq_source_model.sv
`timescale 1ns/1ps
module ssv_irq_source_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Bench requests and device acknowledge
	input wire logic [15:0] raise,
	input wire logic [15:0] irqAck,
	// Level requests to the device
	output logic [15:0] irqPending
);
	// sixteen held flags
	// Held until acknowledged, so a late take is still seen
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			irqPending <= 16'h0000;
		else
			// New event wins over a same-cycle acknowledge
			irqPending <= (irqPending & ~irqAck) | raise;
	end
endmodule : ssv_irq_source_model

//--- sim/ssv_status_stack_vector_unit_tb_top.sv
`timescale 1ns/1ps
module ssv_status_stack_vector_unit_tb_top;
	import ssv_pkg::*;
	logic clk, rst_n, ioWrEn, ioRdEn, instrDone, vectorValid;
	logic [5:0] ioAddr;
	logic [7:0] ioWrData, ioRdData, aluOperandA, aluOperandB, aluResult, statusFlags, rd;
	logic [9:0] stackPointer;
	logic [15:0] irqPending, irqEnable, irqAck, raise;
	logic [4:0] vectorAddr;
	logic [13:0] expAlu;
	logic [5:0] fl;
	logic [31:0] seed = 32'h00000059;
	ssv_alu_op_e aluOp;
	ssv_stack_op_e stackOp;
	int badCount, checked, sp, opIdx, win;
	int pendQ[$];
	ssv_alu_op_e aluTab[7] = '{SSV_ALU_ADD, SSV_ALU_ADC, SSV_ALU_SUB, SSV_ALU_SBC, SSV_ALU_AND, SSV_ALU_OR,
		SSV_ALU_XOR};
	ssv_stack_op_e stkTab[5] = '{SSV_STK_PUSH, SSV_STK_POP, SSV_STK_CALL, SSV_STK_SUB_RETURN,
		SSV_STK_INT_RETURN};
	int stkDelta[5] = '{-1, 1, -2, 2, 2};

	ssv_status_stack_vector_unit dut (.clk(clk), .rst_n(rst_n), .ioAddr(ioAddr), .ioWrEn(ioWrEn),
		.ioWrData(ioWrData), .ioRdEn(ioRdEn), .ioRdData(ioRdData), .aluOp(aluOp),
		.aluOperandA(aluOperandA), .aluOperandB(aluOperandB), .aluResult(aluResult), .stackOp(stackOp),
		.instrDone(instrDone), .stackPointer(stackPointer), .statusFlags(statusFlags),
		.irqPending(irqPending), .irqEnable(irqEnable), .irqAck(irqAck), .vectorValid(vectorValid),
		.vectorAddr(vectorAddr));
	ssv_irq_source_model peer (.clk(clk), .rst_n(rst_n), .raise(raise), .irqAck(irqAck),
		.irqPending(irqPending));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	function automatic logic [31:0] nextRand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : nextRand

	// Flags {H,S,V,N,Z,C} and result; logic ops keep H and C
	function automatic logic [13:0] aluRef(int op, logic [7:0] a, logic [7:0] b, logic [5:0] f);
		logic [7:0] r;
		logic h, v, c;
		int cin;
		h = f[5];
		c = f[0];
		v = 1'b0;
		cin = (op == 1 || op == 3) ? int'(f[0]) : 0;
		case (op)
			0, 1: begin
				r = 8'(int'(a) + int'(b) + cin);
				c = (int'(a) + int'(b) + cin) > 255;
				h = (int'(a[3:0]) + int'(b[3:0]) + cin) > 15;
				v = (a[7] == b[7]) && (r[7] != a[7]);
			end
			2, 3: begin
				r = 8'(int'(a) - int'(b) - cin);
				c = int'(a) < int'(b) + cin;
				h = int'(a[3:0]) < int'(b[3:0]) + cin;
				v = (a[7] != b[7]) && (r[7] != a[7]);
			end
			4: r = a & b;
			5: r = a | b;
			default: r = a ^ b;
		endcase
		return {h, r[7] ^ v, v, r[7], r == 8'h00, c, r};
	endfunction : aluRef

	task step();
		@(posedge clk);
		#1;
	endtask : step

	task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (exp !== got) begin
			badCount++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// Pending sources as a set of indices
	task automatic markPending(input int s);
		for (int k = 0; k < pendQ.size(); k++) begin
			if (pendQ[k] == s)
				return;
		end
		pendQ.push_back(s);
	endtask : markPending

	// Reference winner: lowest pending index, removed once served
	task automatic takeLowest();
		int pos;
		pos = 0;
		for (int k = 1; k < pendQ.size(); k++) begin
			if (pendQ[k] < pendQ[pos])
				pos = k;
		end
		win = pendQ[pos];
		pendQ.delete(pos);
	endtask : takeLowest

	// Strobe dropped for a full cycle so back-to-back calls never double-drive
	task wr(input logic [5:0] a, input logic [7:0] d);
		ioAddr = a;
		ioWrData = d;
		ioWrEn = 1'b1;
		step();
		ioWrEn = 1'b0;
		step();
	endtask : wr

	task rdReg(input logic [5:0] a);
		ioAddr = a;
		ioRdEn = 1'b1;
		step();
		ioRdEn = 1'b0;
		rd = ioRdData;
		step();
	endtask : rdReg

	task results();
		$display("Checks %0d, mismatches %0d", checked, badCount);
		if (badCount == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results

	initial begin
		repeat (2000) @(posedge clk);
		badCount++;
		results();
	end

	initial begin
		rst_n = 1'b0;
		{ioAddr, ioWrEn, ioRdEn, ioWrData, aluOperandA, aluOperandB, instrDone, irqEnable, raise} = '0;
		aluOp = SSV_ALU_NONE;
		stackOp = SSV_STK_NONE;
		repeat (10) @(posedge clk);
		#1 rst_n = 1'b1;
		step();
		chk("reset vector", 16'h0020, {10'h000, vectorValid, vectorAddr});
		rdReg(6'h3E);
		chk("pointer high reset", 16'h0000, {8'h00, rd});
		wr(6'h3E, 8'hFF);
		rdReg(6'h3E);
		chk("pointer high unused", 16'h0003, {8'h00, rd});
		wr(6'h3E, 8'h02);
		wr(6'h3D, 8'h5F);
		sp = 10'h25F;
		rdReg(6'h3D);
		chk("pointer low read", 16'h005F, {8'h00, rd});
		for (int k = 0; k < 24; k++) begin
			opIdx = nextRand() % 5;
			stackOp = stkTab[opIdx];
			step();
			sp = (sp + stkDelta[opIdx]) & 10'h3FF;
			chk("stack pointer", 16'(sp), {6'h00, stackPointer});
		end
		stackOp = SSV_STK_NONE;
		wr(6'h3E, 8'h02);
		wr(6'h3D, 8'h5F);
		sp = 10'h25F;
		fl = 6'h00;
		for (int k = 0; k < 40; k++) begin
			opIdx = nextRand() % 7;
			aluOp = aluTab[opIdx];
			aluOperandA = 8'(nextRand());
			aluOperandB = 8'(nextRand());
			expAlu = aluRef(opIdx, aluOperandA, aluOperandB, fl);
			step();
			fl = expAlu[13:8];
			chk("alu result", {8'h00, expAlu[7:0]}, {8'h00, aluResult});
			chk("status flags", {10'h000, fl}, {8'h00, statusFlags});
		end
		aluOp = SSV_ALU_NONE;
		raise = 16'h0001;
		markPending(0);
		step();
		raise = 16'h0000;
		irqEnable = 16'hFFFF;
		instrDone = 1'b1;
		step();
		instrDone = 1'b0;
		chk("no take global off", 16'h0000, {15'h0000, vectorValid});
		wr(6'h3F, {2'b10, fl});
		irqEnable = 16'hFFFE;
		instrDone = 1'b1;
		step();
		instrDone = 1'b0;
		chk("no take source off", 16'h0000, {15'h0000, vectorValid});
		irqEnable = 16'hFFFF;
		// Two sources at once (only source 15 in the last round); the lower index must win each round
		for (int i = 0; i < 16; i++) begin
			raise = (16'h0001 << i) | (16'h0002 << i);
			markPending(i);
			if (i < 15)
				markPending(i + 1);
			step();
			raise = 16'h0000;
			instrDone = 1'b1;
			step();
			instrDone = 1'b0;
			sp = sp - 2;
			takeLowest();
			chk("vector strobe", 16'h0001, {15'h0000, vectorValid});
			chk("vector", 16'(win + 1), {11'h000, vectorAddr});
			chk("acknowledge", 16'h0001 << win, irqAck);
			chk("entry pointer", 16'(sp), {6'h00, stackPointer});
			chk("entry flags", {10'h000, fl}, {8'h00, statusFlags});
			// Every vector jumps to a bare return
			stackOp = SSV_STK_INT_RETURN;
			instrDone = 1'b1;
			step();
			stackOp = SSV_STK_NONE;
			instrDone = 1'b0;
			sp = sp + 2;
			chk("return flags", {10'h002, fl}, {8'h00, statusFlags});
			chk("return pointer", 16'(sp), {6'h00, stackPointer});
			chk("acknowledge pulse", 16'h0000, irqAck);
		end
		chk("pending left", 16'h0000, irqPending);
		// Reset again mid-run; the reset vector must come once more
		rst_n = 1'b0;
		step();
		chk("reset pointer", 16'h0000, {6'h00, stackPointer});
		chk("reset flags", 16'h0000, {8'h00, statusFlags});
		chk("reset vector off", 16'h0000, {10'h000, vectorValid, vectorAddr});
		rst_n = 1'b1;
		step();
		chk("reset vector again", 16'h0020, {10'h000, vectorValid, vectorAddr});
		step();
		chk("reset vector pulse", 16'h0000, {10'h000, vectorValid, vectorAddr});
		results();
	end
endmodule : ssv_status_stack_vector_unit_tb_top
